// file: rtl/mri_fifo.sv
// Small shift-register FIFO; the head entry is always a register.
// Assumes synchronous active-low reset; out side may stall to let it fill.
`timescale 1ns/1ns
module mri_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 4
) (
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int CW = $clog2(DEPTH + 1);

	logic [W-1:0]  mem [DEPTH];
	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic          push;
	logic          pop;

	assign push       = in_valid && in_ready;
	assign pop        = out_valid && out_ready;
	assign next_count = CW'(count + CW'(push) - CW'(pop));
	assign out_data   = mem[0];

	// Occupancy and honest flags
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			count     <= '0;
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			count     <= next_count;
			in_ready  <= next_count < CW'(DEPTH);
			out_valid <= next_count != '0;
		end
	end

	// Entries shift toward the head on pop
	for (genvar i = 0; i < DEPTH; i++) begin : g_ent
		always_ff @(posedge clk) begin
			if (pop) begin
				if (push && CW'(i + 1) == count)
					mem[i] <= in_data;
				else if (i < DEPTH - 1)
					mem[i] <= mem[(i < DEPTH - 1) ? i + 1 : i];
			end else if (push && CW'(i) == count) begin
				mem[i] <= in_data;
			end
		end
	end
endmodule : mri_fifo

// file: rtl/mri_issue_accept.sv
// Memory reference issue/accept path: priority arbiter, retry hopper, bank
// busy and accept logic, and the data distributor with a write-word FIFO.
// Assumes requesters hold req_valid until taken and storage echoes read tags.
`timescale 1ns/1ns
module mri_issue_accept
	import mri_pkg::*;
#(
	parameter int N_REQ = 4
) (
	input  wire logic                  clk,
	input  wire logic                  reset_n,
	input  wire logic [N_REQ-1:0]      req_valid,
	input  mri_ref_s [N_REQ-1:0]       req,
	output logic [N_REQ-1:0]           req_take,
	output logic                       iss_valid,
	output logic [ADDR_W-1:0]          iss_addr,
	output logic                       go_valid,
	output mri_ref_s                   go_ref,
	output logic                       acc_line,
	output logic                       tag_valid,
	output mri_tag_s                   tag_out,
	output logic                       rd_tag_valid,
	output mri_tag_s                   rd_tag,
	input  wire logic                  wr_in_valid,
	output logic                       wr_in_ready,
	input  mri_wr_s                    wr_in,
	output logic                       wr_bcast_valid,
	output logic [WORD_W-1:0]          wr_bcast_word,
	output logic [N_BANKS-1:0]         wr_bank_en,
	input  wire logic                  store_rd_valid,
	input  mri_rd_s                    store_rd,
	output logic                       rd_valid,
	output mri_rd_s                    rd_out
);
	localparam int LAST = ACCEPT_TICKS - 1;

	logic [DIV_W-1:0]     div;
	logic                 tick;
	mri_hop_s             hop [ACCEPT_TICKS];
	logic                 retry;
	logic                 accepted;
	logic                 next_iss_valid;
	mri_ref_s             next_iss;
	logic [AGE_W-1:0]     next_age;
	logic [N_REQ-1:0]     next_grant;
	logic [CNT_W-1:0]     bank_cnt [N_BANKS];
	logic [N_BANKS-1:0]   bank_hit;
	logic [N_CHASSIS-1:0] chassis_acc;
	logic [BANK_BITS-1:0] sel_bank;
	logic                 fifo_valid;
	mri_wr_s              fifo_data;
	logic                 fifo_pop;

	// Minor cycle enable from the clock divider
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			div  <= '0;
			tick <= 1'b0;
		end else begin
			div  <= (div == DIV_W'(MINOR_CLKS - 1)) ? '0 : DIV_W'(div + 1'b1);
			tick <= div == DIV_W'(MINOR_CLKS - 2); // R19
		end
	end

	// Retry of the oldest hopper entry beats any new request
	assign accepted = hop[LAST].valid && acc_line;
	assign retry    = hop[LAST].valid && !acc_line;

	always_comb begin
		next_iss_valid = 1'b0;
		next_iss       = hop[LAST].ref_;
		next_age       = AGE_W'(hop[LAST].age + 1'b1); // R7
		next_grant     = '0;
		if (retry) begin
			next_iss_valid = 1'b1; // R5
		end else begin
			for (int i = 0; i < N_REQ; i++) begin
				if (!next_iss_valid && req_valid[i]) begin
					next_iss_valid = 1'b1; // R1
					next_iss       = req[i];
					next_age       = '0;
					next_grant[i]  = 1'b1;
				end
			end
		end
	end

	// Grant pulse back to the chosen requester
	always_ff @(posedge clk) begin
		if (!reset_n)
			req_take <= '0;
		else
			req_take <= tick ? next_grant : '0; // R1
	end

	// One address issued per minor cycle
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			iss_valid <= 1'b0;
			iss_addr  <= '0;
		end else begin
			iss_valid <= tick && next_iss_valid; // R2
			if (tick && next_iss_valid)
				iss_addr <= next_iss.addr;
		end
	end

	// Hopper: copy saved at issue, aged one slot per minor cycle
	for (genvar k = 0; k < ACCEPT_TICKS; k++) begin : g_hop
		always_ff @(posedge clk) begin
			if (!reset_n) begin
				hop[k] <= '0;
			end else if (tick) begin
				if (k == 0)
					hop[k] <= '{valid: next_iss_valid, ref_: next_iss, age: next_age}; // R4 R5
				else
					hop[k] <= '{valid: hop[(k > 0) ? k - 1 : 0].valid,
						ref_: hop[(k > 0) ? k - 1 : 0].ref_,
						age: AGE_W'(hop[(k > 0) ? k - 1 : 0].age + 1'b1)}; // R6
			end
		end
	end

	// Bank decode: five low bits pick chassis and bank; busy banks ignore
	assign sel_bank = next_iss.addr[BANK_BITS-1:0]; // R16
	for (genvar b = 0; b < N_BANKS; b++) begin : g_bank
		assign bank_hit[b] = tick && next_iss_valid && sel_bank == BANK_BITS'(b)
			&& bank_cnt[b] == '0; // R3 R17
		always_ff @(posedge clk) begin
			if (!reset_n)
				bank_cnt[b] <= '0;
			else if (bank_hit[b])
				bank_cnt[b] <= CNT_W'(STORE_TICKS);
			else if (tick && bank_cnt[b] != '0)
				bank_cnt[b] <= CNT_W'(bank_cnt[b] - 1'b1);
		end
	end

	// Per-chassis accepts, then the single OR onto the accept line
	for (genvar c = 0; c < N_CHASSIS; c++) begin : g_ch
		always_ff @(posedge clk) begin
			if (!reset_n)
				chassis_acc[c] <= 1'b0;
			else if (tick)
				chassis_acc[c] <= |bank_hit[c*BANKS_PER_CH +: BANKS_PER_CH]; // R14
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n)
			acc_line <= 1'b0;
		else if (tick)
			acc_line <= |chassis_acc; // R15 R18
	end

	// Go to the storage sequencer of the selected bank
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			go_valid <= 1'b0;
			go_ref   <= '0;
		end else begin
			go_valid <= |bank_hit;
			if (|bank_hit)
				go_ref <= next_iss;
		end
	end

	// Tags forwarded on accept; read tags also go to storage for the echo
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			tag_valid    <= 1'b0;
			tag_out      <= '0;
			rd_tag_valid <= 1'b0;
			rd_tag       <= '0;
		end else begin
			tag_valid    <= tick && accepted; // R11
			rd_tag_valid <= tick && accepted && hop[LAST].ref_.tag.kind == MRI_READ;
			if (tick && accepted) begin
				tag_out <= hop[LAST].ref_.tag; // R10
				rd_tag  <= hop[LAST].ref_.tag;
			end
		end
	end

	// Write words wait in the FIFO until the distributor slot comes
	mri_fifo #(
		.W     ($bits(mri_wr_s)),
		.DEPTH (FIFO_DEPTH)
	) u_wr_fifo (
		.clk       (clk),
		.reset_n   (reset_n),
		.in_valid  (wr_in_valid),
		.in_ready  (wr_in_ready),
		.in_data   (wr_in),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_data)
	); // R12

	assign fifo_pop = tick && fifo_valid; // R8

	// Broadcast to all banks with a one-hot store enable
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wr_bcast_valid <= 1'b0;
			wr_bcast_word  <= '0;
			wr_bank_en     <= '0;
		end else begin
			wr_bcast_valid <= fifo_pop;
			if (fifo_pop) begin
				wr_bcast_word <= fifo_data.word;
				wr_bank_en    <= N_BANKS'(1) << fifo_data.bank; // R9
			end else begin
				wr_bank_en    <= '0;
			end
		end
	end

	// Read words routed onward with their tags
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rd_valid <= 1'b0;
			rd_out   <= '0;
		end else begin
			rd_valid <= store_rd_valid; // R13
			if (store_rd_valid)
				rd_out <= store_rd;
		end
	end

	// Checks on issue, retry and accept timing
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_issue_hit;
		tick && next_iss_valid && |bank_hit;
	endsequence
	sequence s_acc_back;
		##(MINOR_CLKS + 1) acc_line ##(MINOR_CLKS - 1) accepted;
	endsequence

	property p_one_take;
		req_take != '0 |-> $onehot(req_take) && $past(tick);
	endproperty
	a_one_take: assert property (p_one_take) else $error("more than one grant or off-tick grant"); // R1

	property p_issue_rate;
		iss_valid |=> !iss_valid [*8];
	endproperty
	a_issue_rate: assert property (p_issue_rate) else $error("issue rate above one per minor cycle"); // R2

	property p_save;
		tick && next_iss_valid |=> hop[0].valid && hop[0].ref_ == $past(next_iss);
	endproperty
	a_save: assert property (p_save) else $error("issued address not saved"); // R4

	property p_retry;
		tick && retry |=> iss_valid && iss_addr == $past(hop[LAST].ref_.addr) && req_take == '0;
	endproperty
	a_retry: assert property (p_retry) else $error("unaccepted address not reissued"); // R5

	// References issued and not yet accepted, counted apart from the hopper slots
	logic [2:0] pend;
	always_ff @(posedge clk) begin
		if (!reset_n)
			pend <= '0;
		else if (tick)
			pend <= 3'(pend + 3'(|next_grant) - 3'(accepted));
	end

	property p_hop_max;
		pend <= 3'(HOP_MAX);
	endproperty
	a_hop_max: assert property (p_hop_max) else $error("hopper over capacity"); // R6

	property p_deadline;
		hop[LAST].valid |-> hop[LAST].age < AGE_W'(ACCEPT_MAX_TICKS);
	endproperty
	a_deadline: assert property (p_deadline) else $error("address not accepted in time"); // R7

	property p_accept_time;
		s_issue_hit |-> s_acc_back;
	endproperty
	a_accept_time: assert property (p_accept_time) else $error("accept not back after two minor cycles"); // R15

	property p_busy;
		tick && next_iss_valid && bank_cnt[sel_bank] != '0 |-> bank_hit == '0;
	endproperty
	a_busy: assert property (p_busy) else $error("busy bank accepted"); // R17

	property p_or;
		tick |=> acc_line == |$past(chassis_acc);
	endproperty
	a_or: assert property (p_or) else $error("accept line not OR of chassis"); // R18

	property p_tags;
		tick && accepted |=> tag_valid && tag_out == $past(hop[LAST].ref_.tag);
	endproperty
	a_tags: assert property (p_tags) else $error("tags not forwarded on accept"); // R11

	property p_bcast;
		wr_bcast_valid |-> $onehot(wr_bank_en) ##1 !wr_bcast_valid [*8];
	endproperty
	a_bcast: assert property (p_bcast) else $error("write broadcast malformed or too fast"); // R8 R9
endmodule : mri_issue_accept

// file: rtl/mri_pkg.sv
// Constants, types and carriers for the memory reference issue and accept path.
// Assumes a single 100 MHz clock; all intervals are counted in 100 ns minor cycles.
// Summary of operation
// R1 - Priority arbiter takes one address per minor cycle
// R2 - At most one address issued per minor cycle
// R3 - Address goes to all banks; free one accepts
// R4 - Each issued address is saved in hopper
// R5 - Unaccepted address re-issued and saved until accepted
// R6 - Hopper holds at most three pending addresses
// R7 - Every address accepted within 2000 ns
// R8 - Distributor moves one word per minor cycle
// R9 - Write word broadcast; only addressed bank stores
// R10 - Requester supplies routing tags with each address
// R11 - On accept, tags go to distributor and reader
// R12 - Write word held in distributor until stored
// R13 - Read word routed to requester named by tags
// R14 - Eight chassis of four banks each
// R15 - Accept returns 200 ns after issue
// R16 - Low five address bits: chassis and bank
// R17 - Busy bank sends no accept, ignores address
// R18 - Per-chassis accepts merged by one OR
// R19 - Single clock, 100 ns minor cycle enable
package mri_pkg;
	localparam int CLK_NS           = 10;
	localparam int MINOR_NS         = 100;
	localparam int MINOR_CLKS       = MINOR_NS / CLK_NS;
	localparam int ACCEPT_NS        = 200;
	localparam int ACCEPT_TICKS     = ACCEPT_NS / MINOR_NS;
	localparam int STORE_NS         = 1000;
	localparam int STORE_TICKS      = STORE_NS / MINOR_NS;
	localparam int ACCEPT_MAX_NS    = 2000;
	localparam int ACCEPT_MAX_TICKS = ACCEPT_MAX_NS / MINOR_NS;
	localparam int HOP_MAX          = 3;
	localparam int N_CHASSIS        = 8;
	localparam int BANKS_PER_CH     = 4;
	localparam int N_BANKS          = N_CHASSIS * BANKS_PER_CH;
	localparam int BANK_BITS        = 5;
	localparam int ADDR_W           = 17;
	localparam int WORD_W           = 60;
	localparam int SRC_W            = 3;
	localparam int DEST_W           = 4;
	localparam int FIFO_DEPTH       = 4;
	localparam int DIV_W            = 4;
	localparam int CNT_W            = 4;
	localparam int AGE_W            = 5;

	typedef enum logic [1:0] {
		MRI_READ,
		MRI_WRITE,
		MRI_EXCH
	} mri_kind_e;

	// Routing tags that travel with an address
	typedef struct packed {
		logic [SRC_W-1:0]  sender;
		logic [DEST_W-1:0] dest;
		mri_kind_e         kind;
	} mri_tag_s;

	typedef struct packed {
		mri_tag_s          tag;
		logic [ADDR_W-1:0] addr;
	} mri_ref_s;

	typedef struct packed {
		logic                 valid;
		mri_ref_s             ref_;
		logic [AGE_W-1:0]     age;
	} mri_hop_s;

	typedef struct packed {
		logic [BANK_BITS-1:0] bank;
		logic [WORD_W-1:0]    word;
	} mri_wr_s;

	typedef struct packed {
		mri_tag_s          tag;
		logic [WORD_W-1:0] word;
	} mri_rd_s;
endpackage : mri_pkg

// file: test/mri_req_model.sv
// Requesters and storage read echo on the far side of the issue/accept path.
// Assumes the bench posts references; read words are derived from echoed tags.
`timescale 1ns/1ns
module mri_req_model
	import mri_pkg::*;
#(
	parameter int N_REQ = 4
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic [N_REQ-1:0] post,
	input  mri_ref_s [N_REQ-1:0]  post_ref,
	input  wire logic [N_REQ-1:0] req_take,
	output logic [N_REQ-1:0]      req_valid,
	output mri_ref_s [N_REQ-1:0]  req,
	input  wire logic             rd_tag_valid,
	input  mri_tag_s              rd_tag,
	output logic                  store_rd_valid,
	output mri_rd_s               store_rd
);
	// Each request is held until granted; a released line toggles every cycle
	always_ff @(posedge clk) begin
		for (int i = 0; i < N_REQ; i++) begin
			if (!reset_n) begin
				req_valid[i] <= 1'b0;
				req[i]       <= '0;
			end else if (post[i]) begin
				req_valid[i] <= 1'b1;
				req[i]       <= post_ref[i];
			end else if (req_take[i] || !req_valid[i]) begin
				req_valid[i] <= 1'b0;
				req[i]       <= ~req[i];
			end
		end
	end

	// Storage returns the read word one cycle after the read tags arrive
	always_ff @(posedge clk) begin
		store_rd_valid <= reset_n && rd_tag_valid;
		if (!reset_n) begin
			store_rd <= '0;
		end else if (rd_tag_valid) begin
			store_rd <= {rd_tag, 51'h0, rd_tag};
		end else begin
			store_rd <= ~store_rd;
		end
	end
endmodule : mri_req_model

// file: test/tb.sv
// Self-checking bench for the memory reference issue/accept path.
// Assumes a 100 MHz clock and the requester/storage model beside the block.
`timescale 1ns/1ns
module tb
	import mri_pkg::*;
;
	typedef struct {
		int       idx;
		mri_ref_s r;
	} mri_row_s;
	localparam int N_REQ = 4;
	localparam int LIMIT = 3000;
	logic                 clk = 1'b0;
	logic                 reset_n = 1'b0;
	logic [N_REQ-1:0]     post = '0;
	mri_ref_s [N_REQ-1:0] post_ref = '0;
	logic [N_REQ-1:0]     req_valid, req_take;
	mri_ref_s [N_REQ-1:0] req;
	logic                 iss_valid, go_valid, acc_line, tag_valid, rd_tag_valid, store_rd_valid, rd_valid;
	logic [ADDR_W-1:0]    iss_addr;
	mri_ref_s             go_ref;
	mri_tag_s             tag_out, rd_tag;
	logic                 wr_in_valid = 1'b0;
	logic                 wr_in_ready, wr_bcast_valid;
	mri_wr_s              wr_in = '0;
	logic [WORD_W-1:0]    wr_bcast_word;
	logic [N_BANKS-1:0]   wr_bank_en;
	mri_rd_s              store_rd, rd_out;
	mri_wr_s              wq [$];
	mri_wr_s              w;
	int                   cyc = 0, checks = 0, num_errors = 0, pushes = 0, nb = 0, t_wr = 0;
	mri_row_s             rows [4] = '{
		'{0, '{'{3'h0, 4'h1, MRI_READ}, 17'h1_0000}},
		'{1, '{'{3'h1, 4'h2, MRI_WRITE}, 17'h0_001F}},
		'{2, '{'{3'h2, 4'h3, MRI_EXCH}, 17'h0_ABC5}},
		'{3, '{'{3'h3, 4'h4, MRI_READ}, 17'h1_FFEA}}
	};

	mri_issue_accept #(.N_REQ(N_REQ)) i_mri_issue_accept (
		.clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req(req), .req_take(req_take),
		.iss_valid(iss_valid), .iss_addr(iss_addr), .go_valid(go_valid), .go_ref(go_ref), .acc_line(acc_line),
		.tag_valid(tag_valid), .tag_out(tag_out), .rd_tag_valid(rd_tag_valid), .rd_tag(rd_tag),
		.wr_in_valid(wr_in_valid), .wr_in_ready(wr_in_ready), .wr_in(wr_in), .wr_bcast_valid(wr_bcast_valid),
		.wr_bcast_word(wr_bcast_word), .wr_bank_en(wr_bank_en), .store_rd_valid(store_rd_valid),
		.store_rd(store_rd), .rd_valid(rd_valid), .rd_out(rd_out)
	);

	mri_req_model #(.N_REQ(N_REQ)) i_mri_req_model (
		.clk(clk), .reset_n(reset_n), .post(post), .post_ref(post_ref), .req_take(req_take),
		.req_valid(req_valid), .req(req), .rd_tag_valid(rd_tag_valid), .rd_tag(rd_tag),
		.store_rd_valid(store_rd_valid), .store_rd(store_rd)
	);

	// Clock generator
	always #(CLK_NS / 2) clk = ~clk;

	task final_report();
		$display("checks %0d, mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : final_report

	task automatic chk(input logic ok, input string msg);
		checks++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("wrong value at %0t ns: %s", $time, msg);
		end
	endtask : chk

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	task automatic wait_take();
		int n = 0;
		do begin
			step(1);
			n++;
		end while (req_take === '0 && n < 4 * MINOR_CLKS);
	endtask : wait_take

	// One reference from post to tags and, for reads, the routed word
	task automatic run_ref(input int idx, input mri_ref_s r);
		logic rd;
		rd = (r.tag.kind == MRI_READ);
		@(posedge clk);
		post_ref[idx] <= r;
		post[idx]     <= 1'b1;
		@(posedge clk);
		post <= '0;
		wait_take();
		chk(req_take === N_REQ'(1 << idx) && iss_valid === 1'b1 && iss_addr === r.addr, "grant and issue");
		chk(go_valid === 1'b1 && go_ref === r, "free bank accepts");
		step(MINOR_CLKS);
		chk(acc_line === 1'b1, "accept line");
		step(MINOR_CLKS);
		chk(tag_valid === 1'b1 && tag_out === r.tag && rd_tag_valid === rd &&
			(!rd || rd_tag === r.tag), "tags forwarded");
		step(2);
		chk(rd_valid === rd && (!rd || rd_out === {r.tag, 51'h0, r.tag}), "read word routed");
	endtask : run_ref

	// Write source and broadcast checker; idle source lines toggle
	always @(posedge clk) begin
		if (reset_n && wr_in_valid && wr_in_ready === 1'b1) begin
			wq.push_back(wr_in);
			pushes++;
			wr_in <= '{wr_in.bank + 5'h07, wr_in.word + 60'h1};
		end else if (!wr_in_valid) begin
			wr_in <= ~wr_in;
		end
		if (wr_bcast_valid === 1'b1) begin
			w = (wq.size() > 0) ? wq.pop_front() : '0;
			chk(wr_bcast_word === w.word && wr_bank_en === (N_BANKS'(1) << w.bank), "write broadcast");
			if (nb > 0) begin
				chk(cyc - t_wr == MINOR_CLKS, "one word per minor cycle");
			end
			nb++;
			t_wr = cyc;
		end
	end

	// Cycle count and hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			num_errors++;
			final_report();
		end
	end

	initial begin
		int         n;
		int         t0;
		logic [9:0] q;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			run_ref(rows[k].idx, rows[k].r);
		end
		// Two requesters at once: lower index first, one issue per minor cycle
		@(posedge clk);
		post_ref[1] <= '{'{3'h1, 4'h5, MRI_WRITE}, 17'h0_0042};
		post_ref[2] <= '{'{3'h2, 4'h6, MRI_EXCH}, 17'h0_0021};
		post <= 4'h6;
		@(posedge clk);
		post <= '0;
		wait_take();
		chk(req_take === 4'h2 && iss_addr === 17'h0_0042, "priority grant");
		step(MINOR_CLKS);
		chk(req_take === 4'h4 && iss_valid === 1'b1 && iss_addr === 17'h0_0021, "next issue");
		step(3 * MINOR_CLKS);
		// Same bank twice: second refused, reissued, accepted in time
		@(posedge clk);
		post_ref[0] <= '{'{3'h0, 4'h7, MRI_WRITE}, 17'h0_0003};
		post_ref[1] <= '{'{3'h1, 4'h8, MRI_READ}, 17'h1_0003};
		post <= 4'h3;
		@(posedge clk);
		post <= '0;
		wait_take();
		step(MINOR_CLKS);
		t0 = cyc;
		chk(iss_valid === 1'b1 && iss_addr === 17'h1_0003 && go_valid === 1'b0, "busy bank refuses");
		step(2 * MINOR_CLKS);
		chk(iss_valid === 1'b1 && iss_addr === 17'h1_0003 && req_take === '0, "address reissued");
		while (!(go_valid === 1'b1 && go_ref.addr === 17'h1_0003) && cyc - t0 < ACCEPT_MAX_TICKS * MINOR_CLKS) begin
			step(1);
		end
		chk(go_valid === 1'b1 && go_ref.addr === 17'h1_0003, "accepted in time");
		step(3 * MINOR_CLKS);
		// Write buffer filled until it refuses, then drained
		@(posedge clk);
		wr_in_valid <= 1'b1;
		n = 0;
		while (wr_in_ready === 1'b1 && n < 30) begin
			step(1);
			n++;
		end
		chk(wr_in_ready === 1'b0 && pushes >= FIFO_DEPTH, "buffer refuses when full");
		step(3 * MINOR_CLKS);
		@(posedge clk);
		wr_in_valid <= 1'b0;
		step(8 * MINOR_CLKS);
		chk(wq.size() == 0 && nb == pushes, "buffer drained in order");
		// Reset in mid-request clears outputs, then service resumes
		@(posedge clk);
		post_ref[0] <= '{'{3'h0, 4'h9, MRI_READ}, 17'h0_0104};
		post[0] <= 1'b1;
		@(posedge clk);
		post <= '0;
		reset_n <= 1'b0;
		step(2);
		q = {req_take, iss_valid, go_valid, acc_line, tag_valid, wr_bcast_valid, rd_valid};
		chk(q === '0 && wr_in_ready === 1'b1, "reset clears outputs");
		@(posedge clk);
		reset_n <= 1'b1;
		run_ref(2, '{'{3'h2, 4'hA, MRI_READ}, 17'h0_0106});
		final_report();
	end
endmodule : tb
